/* File: hdl/swi_defs.vh */
// register map, bit positions and timing constants of the wake controller
`ifndef SWI_DEFS_VH
`define SWI_DEFS_VH

// register byte offsets on the avalon slave
`define SWI_ADDR_W        6
`define SWI_REG_CAUSE     6'h00
`define SWI_REG_ENABLE    6'h04
`define SWI_REG_DIO_DIR   6'h08
`define SWI_REG_DIO_EDGE  6'h0c
`define SWI_REG_WAKE_STAT 6'h10
`define SWI_REG_CTRL      6'h14
`define SWI_REG_STATUS    6'h18
`define SWI_REG_WT0       6'h1c
`define SWI_REG_WT1       6'h20
`define SWI_REG_PC0_REF   6'h24
`define SWI_REG_PC1_REF   6'h28
`define SWI_REG_PRIO      6'h2c
`define SWI_REG_DIO_OUT   6'h30

// cause bitmap positions
`define SWI_BIT_RNG       30
`define SWI_BIT_COMP1     29
`define SWI_BIT_COMP0     28
`define SWI_BIT_WK1       27
`define SWI_BIT_WK0       26
`define SWI_BIT_BO_ENTER  25
`define SWI_BIT_BO_EXIT   24
`define SWI_BIT_PC1       23
`define SWI_BIT_PC0       22
`define SWI_DIO_N         20
`define SWI_CAUSE_VALID   32'h7fcf_ffff
`define SWI_WAKE_MASK     32'h3ccf_ffff

// control register fields
`define SWI_CTRL_SLEEP    0
`define SWI_CTRL_COMP0_RISE 1
`define SWI_CTRL_COMP1_RISE 2
`define SWI_CTRL_PC0_RUN  3
`define SWI_CTRL_PC1_RUN  4
`define SWI_CTRL_UART_EN  5
`define SWI_CTRL_W        6

// status register fields
`define SWI_STAT_ASLEEP   0
`define SWI_STAT_WT0_FIRED 1
`define SWI_STAT_WT1_FIRED 2
`define SWI_STAT_UART     3
`define SWI_STAT_WT0_RUN  4
`define SWI_STAT_WT1_RUN  5

// reset values
`define SWI_RST_ENABLE    32'h0000_0000
`define SWI_RST_DIO_DIR   20'hf_ffff
`define SWI_RST_DIO_EDGE  20'h0_0000
`define SWI_RST_PRIO      32'h0000_0000
`define SWI_RST_CTRL      6'h00

// slow tick: nominal 32 kHz from the 100 MHz clock
`define SWI_SYS_HZ        100000000
`define SWI_SLOW_HZ       32000
`define SWI_TICK_CYCLES   (`SWI_SYS_HZ / `SWI_SLOW_HZ)

`endif

/* File: hdl/swi_edge_det.v */
// per-line edge detector with rising or falling selection
`timescale 1ns/1ps
module swi_edge_det #(
    parameter W = 1
) (
    input  wire         sys_clk_in,
    input  wire         reset_in,
    input  wire [W-1:0] sig_in,
    input  wire [W-1:0] rise_sel_in,
    output reg  [W-1:0] event_out
);
    reg [W-1:0] prev;   // last sampled level
    reg         primed; // first sample after reset seeds prev only

    // one-cycle pulse per selected edge; no spurious edge out of reset
    always @(posedge sys_clk_in) begin
        if (reset_in) begin
            prev      <= {W{1'b0}};
            primed    <= 1'b0;
            event_out <= {W{1'b0}};
        end else begin
            prev   <= sig_in;
            primed <= 1'b1;
            if (primed) begin
                event_out <= (rise_sel_in & sig_in & ~prev) |
                             (~rise_sel_in & ~sig_in & prev);
            end else begin
                event_out <= {W{1'b0}};
            end
        end
    end
endmodule

/* File: hdl/swi_wake_ctrl.v */
// wake source and interrupt aggregation with avalon register slave
//
// Summary of operation
// - enabled timer, line, comparator, counter event wakes
// - two wake timers tick at 32 kHz always
// - timer expiry raises enabled interrupt, waking
// - each timer keeps a readable fired flag
// - twenty lines; input wake lines wake on their selected edge only
// - per-line direction and per-line wake enable
// - per-line rising or falling edge select
// - readable per-line wake status
// - comparator wakes on rise or fall, configurable
// - readable comparator wake status
// - two pulse counters interrupt at reference count
// - wake status kept until pending cleared
// - all system causes share one bitmap interrupt
// - pending flags survive sleep until cleared
// - uart receive interrupt clears only when drained
// - per-source programmable interrupt priority
// - counter one bit 23, zero bit 22
// - comparator one bit 29, zero bit 28
//
// The Avalon-MM slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "swi_defs.vh"
module swi_wake_ctrl #(
    parameter TICK_DIV = `SWI_TICK_CYCLES,
    parameter TMR_W    = 32,
    parameter PC_W     = 16,
    parameter PRIO_N   = 8
) (
    input  wire                   sys_clk_in,
    input  wire                   reset_in,
    input  wire [`SWI_ADDR_W-1:0] avs_address_in,
    input  wire                   avs_read_in,
    input  wire                   avs_write_in,
    input  wire [31:0]            avs_writedata_in,
    input  wire [3:0]             avs_byteenable_in,
    output reg  [31:0]            avs_readdata_out,
    output reg                    avs_waitrequest_out,
    input  wire [`SWI_DIO_N-1:0]  dio_pin_in,
    output reg  [`SWI_DIO_N-1:0]  dio_pin_out,
    output reg  [`SWI_DIO_N-1:0]  dio_pin_oe_out,
    input  wire [1:0]             comp_level_in,
    input  wire [1:0]             pulse_in,
    input  wire                   rng_event_in,
    input  wire                   brownout_enter_in,
    input  wire                   brownout_exit_in,
    input  wire                   uart_rx_avail_in,
    input  wire                   uart_rx_timeout_in,
    input  wire                   uart_rx_empty_in,
    input  wire [PRIO_N-3:0]      periph_irq_in,
    output reg                    sleep_out,
    output reg                    sysctrl_irq_out,
    output reg                    cpu_irq_out,
    output reg  [2:0]             source_identifier_out
);
    localparam [15:0] TICK_LAST = TICK_DIV[15:0] - 16'h0001;

    reg  [31:0]            cause_bitmap;   // pending flags
    reg  [31:0]            enable;         // per-cause interrupt enable
    reg  [31:0]            wake_stat;      // causes latched at wake-up
    reg  [`SWI_DIO_N-1:0]  dio_dir;        // 1 = input
    reg  [`SWI_DIO_N-1:0]  dio_edge;       // 1 = rising edge
    reg  [`SWI_DIO_N-1:0]  dio_out;        // drive level of outputs
    reg  [`SWI_CTRL_W-1:0] ctrl;           // control bits
    reg  [31:0]            prio;           // 4 bits per source
    reg  [15:0]            tick_cnt;       // slow tick divider
    reg                    tick;           // one pulse per 32 kHz period
    reg  [TMR_W-1:0]       wt_cnt0;        // timer 0 remaining ticks
    reg  [TMR_W-1:0]       wt_cnt1;        // timer 1 remaining ticks
    reg  [1:0]             wt_run;         // timers running
    reg  [1:0]             wt_fired;       // timers expired
    reg  [1:0]             wt_evt;         // expiry pulses
    reg  [PC_W-1:0]        pc_cnt0;        // counter 0 value
    reg  [PC_W-1:0]        pc_cnt1;        // counter 1 value
    reg  [PC_W-1:0]        pc_ref0;        // counter 0 reference
    reg  [PC_W-1:0]        pc_ref1;        // counter 1 reference
    reg  [1:0]             pc_evt;         // reference reached pulses
    reg                    uart_flag;      // receive interrupt held
    reg  [31:0]            next_cause;     // pending after this edge
    reg  [31:0]            next_rdata;     // read mux
    reg  [31:0]            raw_evt;        // all events this cycle
    reg  [3:0]             best_p;         // arbiter winner priority
    reg  [2:0]             best_id;        // arbiter winner index
    wire [`SWI_DIO_N-1:0]  dio_evt;        // edge pulses, all lines
    wire [1:0]             comp_evt;       // comparator edge pulses
    wire [1:0]             pulse_evt;      // counter input edges
    wire [PRIO_N-1:0]      irq_req;        // requests into arbiter
    wire                   wr_en;          // write accepted this edge
    wire                   rd_cap;         // read data captured
    wire [31:0]            wmask;          // byte-enabled write data
    integer                i;

    // merge byte lanes of a write into the old value
    function [31:0] be_merge;
        input [31:0] old;
        input [31:0] wdata;
        input [3:0]  be;
        integer      k;
        begin
            be_merge = old;
            for (k = 0; k < 4; k = k + 1) begin
                if (be[k]) begin
                    be_merge[8*k +: 8] = wdata[8*k +: 8];
                end
            end
        end
    endfunction

    assign wr_en  = avs_write_in & ~avs_waitrequest_out;
    assign rd_cap = avs_read_in & avs_waitrequest_out;
    assign wmask  = be_merge(32'h0000_0000, avs_writedata_in,
                             avs_byteenable_in);

    // line edges, polarity chosen per line
    swi_edge_det #(.W(`SWI_DIO_N)) u_dio_edge (
        .sys_clk_in  (sys_clk_in),
        .reset_in    (reset_in),
        .sig_in      (dio_pin_in),
        .rise_sel_in (dio_edge),
        .event_out   (dio_evt)
    );

    // comparator crossings, polarity per comparator
    swi_edge_det #(.W(2)) u_comp_edge (
        .sys_clk_in  (sys_clk_in),
        .reset_in    (reset_in),
        .sig_in      (comp_level_in),
        .rise_sel_in ({ctrl[`SWI_CTRL_COMP1_RISE],
                       ctrl[`SWI_CTRL_COMP0_RISE]}),
        .event_out   (comp_evt)
    );

    // counter inputs count rising edges only
    swi_edge_det #(.W(2)) u_pulse_edge (
        .sys_clk_in  (sys_clk_in),
        .reset_in    (reset_in),
        .sig_in      (pulse_in),
        .rise_sel_in (2'h3),
        .event_out   (pulse_evt)
    );

    // gather every cause at its bitmap bit
    always @* begin
        raw_evt = 32'h0000_0000;
        raw_evt[`SWI_DIO_N-1:0]   = dio_evt & dio_dir;
        raw_evt[`SWI_BIT_PC0]     = pc_evt[0];
        raw_evt[`SWI_BIT_PC1]     = pc_evt[1];
        raw_evt[`SWI_BIT_BO_EXIT] = brownout_exit_in;
        raw_evt[`SWI_BIT_BO_ENTER] = brownout_enter_in;
        raw_evt[`SWI_BIT_WK0]     = wt_evt[0];
        raw_evt[`SWI_BIT_WK1]     = wt_evt[1];
        raw_evt[`SWI_BIT_COMP0]   = comp_evt[0];
        raw_evt[`SWI_BIT_COMP1]   = comp_evt[1];
        raw_evt[`SWI_BIT_RNG]     = rng_event_in;
        // disabled sources never become pending, so never wake
        next_cause = cause_bitmap;
        if (wr_en && avs_address_in == `SWI_REG_CAUSE) begin
            next_cause = cause_bitmap & ~wmask;
        end
        // set after clear: an event in the clear cycle survives
        next_cause = next_cause |
                     (raw_evt & enable & `SWI_CAUSE_VALID);
    end

    // pending flags and wake cause, untouched by sleep itself
    always @(posedge sys_clk_in) begin
        if (reset_in) begin
            cause_bitmap <= 32'h0000_0000;
            wake_stat    <= 32'h0000_0000;
        end else begin
            cause_bitmap <= next_cause;
            if (sleep_out && |(cause_bitmap & `SWI_WAKE_MASK)) begin
                wake_stat <= cause_bitmap & `SWI_WAKE_MASK;
            end else begin
                wake_stat <= wake_stat & next_cause;
            end
        end
    end

    // sleep state: wake on any pending wake-capable cause
    always @(posedge sys_clk_in) begin
        if (reset_in) begin
            sleep_out <= 1'b0;
        end else if (sleep_out) begin
            if (|(cause_bitmap & `SWI_WAKE_MASK)) begin
                sleep_out <= 1'b0;
            end
        end else if (wr_en && avs_address_in == `SWI_REG_CTRL &&
                     wmask[`SWI_CTRL_SLEEP]) begin
            sleep_out <= 1'b1;
        end
    end

    // software-written configuration registers
    always @(posedge sys_clk_in) begin
        if (reset_in) begin
            enable   <= `SWI_RST_ENABLE;
            dio_dir  <= `SWI_RST_DIO_DIR;
            dio_edge <= `SWI_RST_DIO_EDGE;
            dio_out  <= {`SWI_DIO_N{1'b0}};
            ctrl     <= `SWI_RST_CTRL;
            prio     <= `SWI_RST_PRIO;
        end else if (wr_en) begin
            case (avs_address_in)
                `SWI_REG_ENABLE: begin
                    enable <= be_merge(enable, avs_writedata_in,
                                       avs_byteenable_in);
                end
                `SWI_REG_DIO_DIR: begin
                    dio_dir <= wmask[`SWI_DIO_N-1:0];
                end
                `SWI_REG_DIO_EDGE: begin
                    dio_edge <= wmask[`SWI_DIO_N-1:0];
                end
                `SWI_REG_DIO_OUT: begin
                    dio_out <= wmask[`SWI_DIO_N-1:0];
                end
                `SWI_REG_CTRL: begin
                    // sleep bit is a trigger, never stored
                    ctrl <= wmask[`SWI_CTRL_W-1:0] &
                            ~({{(`SWI_CTRL_W-1){1'b0}}, 1'b1});
                end
                `SWI_REG_PRIO: begin
                    prio <= be_merge(prio, avs_writedata_in,
                                     avs_byteenable_in);
                end
                default: begin
                    // timers and counters load elsewhere
                end
            endcase
        end
    end

    // 32 kHz tick from the system clock; keeps running in sleep
    always @(posedge sys_clk_in) begin
        if (reset_in) begin
            tick_cnt <= 16'h0000;
            tick     <= 1'b0;
        end else if (tick_cnt == TICK_LAST) begin
            tick_cnt <= 16'h0000;
            tick     <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 16'h0001;
            tick     <= 1'b0;
        end
    end

    // wake timers: write nonzero to start, zero to stop
    always @(posedge sys_clk_in) begin
        if (reset_in) begin
            wt_cnt0  <= {TMR_W{1'b0}};
            wt_cnt1  <= {TMR_W{1'b0}};
            wt_run   <= 2'h0;
            wt_fired <= 2'h0;
            wt_evt   <= 2'h0;
        end else begin
            wt_evt <= 2'h0;
            if (wr_en && avs_address_in == `SWI_REG_WT0) begin
                wt_cnt0     <= avs_writedata_in[TMR_W-1:0];
                wt_run[0]   <= |avs_writedata_in[TMR_W-1:0];
                wt_fired[0] <= 1'b0;
            end else if (tick && wt_run[0]) begin
                wt_cnt0 <= wt_cnt0 - {{(TMR_W-1){1'b0}}, 1'b1};
                if (wt_cnt0 == {{(TMR_W-1){1'b0}}, 1'b1}) begin
                    wt_run[0]   <= 1'b0;
                    wt_fired[0] <= 1'b1;
                    wt_evt[0]   <= 1'b1;
                end
            end
            if (wr_en && avs_address_in == `SWI_REG_WT1) begin
                wt_cnt1     <= avs_writedata_in[TMR_W-1:0];
                wt_run[1]   <= |avs_writedata_in[TMR_W-1:0];
                wt_fired[1] <= 1'b0;
            end else if (tick && wt_run[1]) begin
                wt_cnt1 <= wt_cnt1 - {{(TMR_W-1){1'b0}}, 1'b1};
                if (wt_cnt1 == {{(TMR_W-1){1'b0}}, 1'b1}) begin
                    wt_run[1]   <= 1'b0;
                    wt_fired[1] <= 1'b1;
                    wt_evt[1]   <= 1'b1;
                end
            end
        end
    end

    // pulse counters wrap to zero on reaching the reference
    always @(posedge sys_clk_in) begin
        if (reset_in) begin
            pc_cnt0 <= {PC_W{1'b0}};
            pc_cnt1 <= {PC_W{1'b0}};
            pc_ref0 <= {PC_W{1'b1}};
            pc_ref1 <= {PC_W{1'b1}};
            pc_evt  <= 2'h0;
        end else begin
            pc_evt <= 2'h0;
            if (wr_en && avs_address_in == `SWI_REG_PC0_REF) begin
                pc_ref0 <= avs_writedata_in[PC_W-1:0];
                pc_cnt0 <= {PC_W{1'b0}};
            end else if (pulse_evt[0] && ctrl[`SWI_CTRL_PC0_RUN]) begin
                if (pc_cnt0 + {{(PC_W-1){1'b0}}, 1'b1} == pc_ref0) begin
                    pc_cnt0   <= {PC_W{1'b0}};
                    pc_evt[0] <= 1'b1;
                end else begin
                    pc_cnt0 <= pc_cnt0 + {{(PC_W-1){1'b0}}, 1'b1};
                end
            end
            if (wr_en && avs_address_in == `SWI_REG_PC1_REF) begin
                pc_ref1 <= avs_writedata_in[PC_W-1:0];
                pc_cnt1 <= {PC_W{1'b0}};
            end else if (pulse_evt[1] && ctrl[`SWI_CTRL_PC1_RUN]) begin
                if (pc_cnt1 + {{(PC_W-1){1'b0}}, 1'b1} == pc_ref1) begin
                    pc_cnt1   <= {PC_W{1'b0}};
                    pc_evt[1] <= 1'b1;
                end else begin
                    pc_cnt1 <= pc_cnt1 + {{(PC_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

    // uart receive interrupt ignores write-one; only draining clears
    always @(posedge sys_clk_in) begin
        if (reset_in) begin
            uart_flag <= 1'b0;
        end else if (ctrl[`SWI_CTRL_UART_EN] &&
                     (uart_rx_avail_in || uart_rx_timeout_in)) begin
            uart_flag <= 1'b1;
        end else if (uart_rx_empty_in) begin
            uart_flag <= 1'b0;
        end
    end

    // requests: 0 system controller, 1 uart, rest external
    assign irq_req = {periph_irq_in, uart_flag,
                      (|cause_bitmap) & ~sleep_out};

    // priority zero masks a source; ties go to the lower index
    always @* begin
        best_p  = 4'h0;
        best_id = 3'h0;
        for (i = 0; i < PRIO_N; i = i + 1) begin
            if (irq_req[i] && prio[4*i +: 4] > best_p) begin
                best_p  = prio[4*i +: 4];
                best_id = i[2:0];
            end
        end
    end

    // registered interrupt and pin outputs
    always @(posedge sys_clk_in) begin
        if (reset_in) begin
            sysctrl_irq_out       <= 1'b0;
            cpu_irq_out           <= 1'b0;
            source_identifier_out <= 3'h0;
            dio_pin_out           <= {`SWI_DIO_N{1'b0}};
            dio_pin_oe_out        <= {`SWI_DIO_N{1'b0}};
        end else begin
            sysctrl_irq_out       <= irq_req[0];
            cpu_irq_out           <= |best_p;
            source_identifier_out <= best_id;
            dio_pin_out           <= dio_out;
            dio_pin_oe_out        <= ~dio_dir;
        end
    end

    // read mux; unmapped offsets read as zero
    always @* begin
        next_rdata = 32'h0000_0000;
        case (avs_address_in)
            `SWI_REG_CAUSE:     next_rdata = cause_bitmap;
            `SWI_REG_ENABLE:    next_rdata = enable;
            `SWI_REG_DIO_DIR:   next_rdata[`SWI_DIO_N-1:0] = dio_dir;
            `SWI_REG_DIO_EDGE:  next_rdata[`SWI_DIO_N-1:0] = dio_edge;
            `SWI_REG_DIO_OUT:   next_rdata[`SWI_DIO_N-1:0] = dio_out;
            `SWI_REG_WAKE_STAT: next_rdata = wake_stat;
            `SWI_REG_CTRL:      next_rdata[`SWI_CTRL_W-1:0] = ctrl;
            `SWI_REG_STATUS: begin
                next_rdata[`SWI_STAT_ASLEEP]    = sleep_out;
                next_rdata[`SWI_STAT_WT0_FIRED] = wt_fired[0];
                next_rdata[`SWI_STAT_WT1_FIRED] = wt_fired[1];
                next_rdata[`SWI_STAT_UART]      = uart_flag;
                next_rdata[`SWI_STAT_WT0_RUN]   = wt_run[0];
                next_rdata[`SWI_STAT_WT1_RUN]   = wt_run[1];
            end
            `SWI_REG_WT0:     next_rdata[TMR_W-1:0] = wt_cnt0;
            `SWI_REG_WT1:     next_rdata[TMR_W-1:0] = wt_cnt1;
            `SWI_REG_PC0_REF: next_rdata[PC_W-1:0] = pc_ref0;
            `SWI_REG_PC1_REF: next_rdata[PC_W-1:0] = pc_ref1;
            `SWI_REG_PRIO:    next_rdata = prio;
            default:          next_rdata = 32'h0000_0000;
        endcase
    end

    // avalon handshake: one wait cycle, then one ready cycle
    always @(posedge sys_clk_in) begin
        if (reset_in) begin
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out    <= 32'h0000_0000;
        end else begin
            if ((avs_read_in || avs_write_in) && avs_waitrequest_out) begin
                avs_waitrequest_out <= 1'b0;
            end else begin
                avs_waitrequest_out <= 1'b1;
            end
            if (rd_cap) begin
                avs_readdata_out <= next_rdata;
            end
        end
    end
endmodule

/* File: verif/swi_wake_chk.sv */
// concurrent checks on the wake controller ports
`timescale 1ns/1ps
`include "swi_defs.vh"
module swi_wake_chk (
    input logic                   sys_clk_in,
    input logic                   reset_in,
    input logic [`SWI_ADDR_W-1:0] avs_address_in,
    input logic                   avs_read_in,
    input logic                   avs_write_in,
    input logic [31:0]            avs_readdata_out,
    input logic                   avs_waitrequest_out,
    input logic [`SWI_DIO_N-1:0]  dio_pin_oe_out,
    input logic                   sleep_out,
    input logic                   sysctrl_irq_out,
    input logic                   cpu_irq_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);
    // request and its answering edge
    wire req  = avs_read_in | avs_write_in;
    wire done = req & ~avs_waitrequest_out;
    wire rdok = done & avs_read_in;
    // direction write: sole mover of the enables
    wire wdir = done & avs_write_in & (avs_address_in == `SWI_REG_DIO_DIR);
    a_wait_single: assert property (req && avs_waitrequest_out
        |=> !avs_waitrequest_out) else $error("request not answered");
    a_wait_pulse: assert property (!avs_waitrequest_out
        |=> avs_waitrequest_out) else $error("wait low too long");
    a_wait_idle: assert property (!req |=> avs_waitrequest_out)
        else $error("wait low with no request");
    a_unmapped_zero: assert property (rdok && avs_address_in > 6'h30
        |-> avs_readdata_out == 32'h0) else $error("hole read not zero");
    a_cause_mask: assert property (
        rdok && avs_address_in == `SWI_REG_CAUSE
        |-> (avs_readdata_out & ~`SWI_CAUSE_VALID) == 32'h0)
        else $error("cause bitmap has unused bits set");
    a_asleep_quiet: assert property (sleep_out |=> !sysctrl_irq_out)
        else $error("combined irq while asleep");
    a_wake_irq: assert property ($fell(sleep_out) |=> sysctrl_irq_out)
        else $error("wake without combined irq");
    a_oe_by_dir: assert property ($changed(dio_pin_oe_out)
        |-> $past(wdir, 1) || $past(wdir, 2))
        else $error("output enable moved without direction write");
    c_wake: cover property ($fell(sleep_out));
    c_cpu_irq: cover property ($rose(cpu_irq_out));
    c_clear: cover property (done && avs_write_in && avs_address_in == 6'h00);
endmodule

bind swi_wake_ctrl swi_wake_chk chk_u (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .dio_pin_oe_out(dio_pin_oe_out), .sleep_out(sleep_out),
    .sysctrl_irq_out(sysctrl_irq_out), .cpu_irq_out(cpu_irq_out)
);

/* File: verif/tb_swi_wake_ctrl.sv */
// self-checking bench for the wake and interrupt controller
`timescale 1ns/1ps
`include "swi_defs.vh"
module tb_swi_wake_ctrl;
    logic        sys_clk_in = 1'b0;
    logic        reset_in = 1'b1;
    logic [5:0]  adr = 6'h00;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [19:0] dio = 20'h0;
    logic [1:0]  comp = 2'h0;
    logic [1:0]  pls = 2'h0;
    logic [5:0]  pirq = 6'h0;
    logic        rng = 1'b0;  // also both brownout pulses
    logic        u_av = 1'b0;  // avail and timeout together
    logic        u_emp = 1'b1;
    logic [31:0] q, rdata, en, edg;
    logic [31:0] seed = 32'hb47e;
    logic [19:0] dout, doe;
    logic        wt, slp, sirq, cirq;
    logic [2:0]  sid;
    integer      failures = 0, checks_done = 0, i;

    swi_wake_ctrl #(.TICK_DIV(4)) dut_u (
        .sys_clk_in(sys_clk_in), .reset_in(reset_in),
        .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
        .avs_writedata_in(wd), .avs_byteenable_in(4'hf),
        .avs_readdata_out(q), .avs_waitrequest_out(wt),
        .dio_pin_in(dio), .dio_pin_out(dout), .dio_pin_oe_out(doe),
        .comp_level_in(comp), .pulse_in(pls), .rng_event_in(rng),
        .brownout_enter_in(rng), .brownout_exit_in(rng),
        .uart_rx_avail_in(u_av), .uart_rx_timeout_in(u_av),
        .uart_rx_empty_in(u_emp), .periph_irq_in(pirq),
        .sleep_out(slp), .sysctrl_irq_out(sirq), .cpu_irq_out(cirq),
        .source_identifier_out(sid)
    );

    // 100 mhz clock
    always #5 sys_clk_in = ~sys_clk_in;

    // xorshift source for random stimulus
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        checks_done++;
        if (got !== want) begin
            failures++;
            $display("ERROR %0t got %h want %h", $time, got, want);
        end
    endtask

    task automatic tick(input integer k);
        repeat (k) @(posedge sys_clk_in);
    endtask

    // one bus cycle, held until wait reads low
    task automatic bus(input logic w, input logic [5:0] a,
                       input logic [31:0] d);
        @(posedge sys_clk_in);
        wr  <= w;
        rd  <= ~w;
        adr <= a;
        wd  <= d;
        do @(posedge sys_clk_in); while (wt !== 1'b0);
        rdata = q;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task automatic rchk(input logic [5:0] a, input logic [31:0] want);
        bus(1'b0, a, 32'h0);
        chk(rdata, want);
    endtask

    task automatic pulse(input logic [1:0] p);
        pls <= p;
        tick(2);
        pls <= 2'h0;
        tick(2);
    endtask

    task automatic close_out();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // watchdog, far beyond the test length
    initial begin
        #300000;
        failures++;
        close_out();
    end

    initial begin
        repeat (20) @(posedge sys_clk_in);
        reset_in <= 1'b0;
        rchk(`SWI_REG_ENABLE, `SWI_RST_ENABLE);
        rchk(`SWI_REG_DIO_DIR, {12'h0, `SWI_RST_DIO_DIR});
        rchk(`SWI_REG_PRIO, `SWI_RST_PRIO);
        rchk(6'h3c, 32'h0);
        $display("reset test done");
        // random enables; disabled causes stay clear
        en  = rnd() & `SWI_CAUSE_VALID;
        edg = rnd() & 32'hf_ffff;
        bus(1'b1, `SWI_REG_ENABLE, en);
        bus(1'b1, `SWI_REG_DIO_EDGE, edg);
        dio <= 20'hf_ffff;
        rng <= 1'b1;
        tick(1);
        rng <= 1'b0;
        tick(4);
        rchk(`SWI_REG_CAUSE, en & (edg | 32'h4300_0000));
        bus(1'b1, `SWI_REG_CAUSE, 32'h4000_00ff);
        rchk(`SWI_REG_CAUSE, en & (edg | 32'h0300_0000) & ~32'hff);
        bus(1'b1, `SWI_REG_CAUSE, 32'hffff_ffff);
        dio <= 20'h0;
        tick(4);
        rchk(`SWI_REG_CAUSE, en & ~edg & 32'hf_ffff);
        // output line must not wake
        bus(1'b1, `SWI_REG_ENABLE, `SWI_CAUSE_VALID);
        bus(1'b1, `SWI_REG_CAUSE, 32'hffff_ffff);
        bus(1'b1, `SWI_REG_DIO_DIR, 32'h000f_fffe);
        bus(1'b1, `SWI_REG_DIO_OUT, 32'h1);
        dio <= 20'h1;
        tick(2);
        dio <= 20'h0;
        tick(4);
        chk(32'({doe, dout}), 32'h0010_0001);
        rchk(`SWI_REG_CAUSE, 32'h0);
        bus(1'b1, `SWI_REG_DIO_DIR, 32'h000f_ffff);
        $display("line test done");
        for (i = 0; i < 2; i++) begin
            bus(1'b1, `SWI_REG_WT0 + 6'(4 * i), 32'h5);
            bus(1'b1, `SWI_REG_CTRL, 32'h1);
            tick(2);
            chk(32'({slp, sirq}), 32'h2);
            while (slp !== 1'b0) tick(1);
            tick(2);
            chk(32'(sirq), 32'h1);
            rchk(`SWI_REG_STATUS, 32'(2 + 4 * i));
            rchk(`SWI_REG_WAKE_STAT, 32'h1 << (26 + i));
            bus(1'b1, `SWI_REG_CAUSE, 32'h1 << (26 + i));
            rchk(`SWI_REG_WAKE_STAT, 32'h0);
        end
        $display("timer test done");
        bus(1'b1, `SWI_REG_PC0_REF, 32'h3);
        bus(1'b1, `SWI_REG_PC1_REF, 32'h2);
        bus(1'b1, `SWI_REG_CTRL, 32'h1a);
        repeat (2) pulse(2'b11);
        rchk(`SWI_REG_CAUSE, 32'h0080_0000);
        pulse(2'b01);
        rchk(`SWI_REG_CAUSE, 32'h00c0_0000);
        comp <= 2'b11;
        tick(4);
        rchk(`SWI_REG_CAUSE, 32'h10c0_0000);
        comp <= 2'b00;
        tick(4);
        rchk(`SWI_REG_CAUSE, 32'h30c0_0000);
        bus(1'b1, `SWI_REG_CAUSE, 32'hffff_ffff);
        $display("counter test done");
        // receive flag holds until drained
        bus(1'b1, `SWI_REG_CTRL, 32'h20);
        bus(1'b1, `SWI_REG_PRIO, 32'h0000_0530);
        u_emp <= 1'b0;
        u_av  <= 1'b1;
        tick(1);
        u_av <= 1'b0;
        tick(3);
        chk(32'({cirq, sid}), 32'h9);
        bus(1'b1, `SWI_REG_CAUSE, 32'hffff_ffff);
        rchk(`SWI_REG_STATUS, 32'he);
        pirq <= 6'h1;
        tick(3);
        chk(32'({cirq, sid}), 32'ha);
        pirq  <= 6'h0;
        u_emp <= 1'b1;
        tick(3);
        rchk(`SWI_REG_STATUS, 32'h6);
        $display("uart test done");
        close_out();
    end
endmodule
